// ### design/dmiu_regs.vh
// constants for the data move instruction unit
`ifndef DMIU_REGS_VH
`define DMIU_REGS_VH
// register offsets (byte addresses)
`define DMIU_CTRL_ADDR     12'h000
`define DMIU_INSN_ADDR     12'h004
`define DMIU_W_ADDR        12'h008
`define DMIU_BSR_ADDR      12'h00C
`define DMIU_PCH_ADDR      12'h010
`define DMIU_PTR0_ADDR     12'h014
`define DMIU_PTR1_ADDR     12'h018
`define DMIU_STAT_ADDR     12'h01C
`define DMIU_MEMA_ADDR     12'h020
`define DMIU_MEMD_ADDR     12'h024
// operation codes in the instruction register
`define DMIU_OP_NONE       3'h0
`define DMIU_OP_ILOAD      3'h1
`define DMIU_OP_ILOADK     3'h2
`define DMIU_OP_BANK       3'h3
`define DMIU_OP_PLATCH     3'h4
`define DMIU_OP_WLIT       3'h5
`define DMIU_OP_WSTORE     3'h6
// address mode field encodings
`define DMIU_MM_PREINC     2'h0
`define DMIU_MM_PREDEC     2'h1
`define DMIU_MM_POSTINC    2'h2
`define DMIU_MM_POSTDEC    2'h3
// instruction register fields
`define DMIU_INSN_OP_LSB   8
`define DMIU_INSN_SEL_BIT  11
`define DMIU_INSN_MM_LSB   12
// status bits
`define DMIU_STAT_Z_BIT    0
`define DMIU_STAT_BUSY_BIT 1
// memory and widths
`define DMIU_MEM_DEPTH     256
`define DMIU_FILE_MASK     7'h7F
`define DMIU_BSR_MASK      4'hF
`endif

// ### design/dmiu_core.v
// data move instruction unit with apb register access
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "dmiu_regs.vh"

// Behaviour
// [RULE_01] indirect load copies memory at selected pointer into working reg
// [RULE_02] mode field: 00 preinc, 01 predec, 10 postinc, 11 postdec
// [RULE_03] address is pointer, pointer+1, pointer-1 or pointer plus signed offset
// [RULE_04] pointer ends +1 on increments, -1 on decrements, same for offset
// [RULE_05] pointers are 16 bits and wrap in both directions
// [RULE_06] zero flag follows loaded value; pointer update touches no flag
// [RULE_07] bank literal loads four-bit value into bank select, flags untouched
// [RULE_08] program latch literal loads seven bits, flags untouched
// [RULE_09] working literal loads eight bits into working reg, flags untouched
// [RULE_10] store copies working register to file register in one cycle
module dmiu_core (
   input  wire        mclk,
   input  wire        rstn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   output reg  [7:0]  working_ff,
   output reg  [3:0]  bank_select_register_ff,
   output reg  [6:0]  program_counter_high_latch_ff,
   output reg         zero_flag_ff,
   output reg         done_ff
);

   reg  [7:0]  mem_ff [0:`DMIU_MEM_DEPTH-1];
   reg  [15:0] pointer_register_ff [0:1];
   reg  [15:0] insn_ff;
   reg         go_ff;
   reg  [7:0]  mem_addr_ff;
   reg  [7:0]  nxt_w;
   reg  [15:0] ea;
   reg  [15:0] nxt_ptr;
   reg         wr_mem;
   reg  [7:0]  wr_addr;
   reg  [31:0] nxt_rdata;
   reg         nxt_err;
   wire [2:0]  op;
   wire        sel;
   wire [1:0]  address_mode_field;
   wire [5:0]  offs;
   wire [7:0]  lit;
   wire        acc;
   wire        wr;
   integer     i;

   assign op  = insn_ff[`DMIU_INSN_OP_LSB +: 3];
   assign sel = insn_ff[`DMIU_INSN_SEL_BIT];
   assign address_mode_field = insn_ff[`DMIU_INSN_MM_LSB +: 2];
   assign offs = insn_ff[5:0];
   assign lit  = insn_ff[7:0];
   assign acc  = psel & penable & ~pready;
   assign wr   = acc & pwrite;

   // address and pointer arithmetic, kept to 16 bits so it wraps
   always @* begin
      ea      = pointer_register_ff[sel];
      nxt_ptr = pointer_register_ff[sel];
      if (op == `DMIU_OP_ILOADK) begin
         ea = pointer_register_ff[sel] + {{10{offs[5]}}, offs}; // [RULE_03]
      end else begin
         case (address_mode_field) // [RULE_02]
            `DMIU_MM_PREINC: begin
               ea      = pointer_register_ff[sel] + 16'h0001; // [RULE_03]
               nxt_ptr = ea; // [RULE_04] [RULE_05]
            end
            `DMIU_MM_PREDEC: begin
               ea      = pointer_register_ff[sel] - 16'h0001; // [RULE_03]
               nxt_ptr = ea; // [RULE_04] [RULE_05]
            end
            `DMIU_MM_POSTINC: begin
               nxt_ptr = pointer_register_ff[sel] + 16'h0001; // [RULE_04]
            end
            `DMIU_MM_POSTDEC: begin
               nxt_ptr = pointer_register_ff[sel] - 16'h0001; // [RULE_05]
            end
            default: begin
               nxt_ptr = pointer_register_ff[sel];
            end
         endcase
      end
      // only the low byte reaches the small data memory
      nxt_w = mem_ff[ea[7:0]]; // [RULE_01]
   end

   // memory write port: apb data writes or the store instruction
   always @* begin
      wr_mem  = 1'b0;
      wr_addr = mem_addr_ff;
      if (go_ff && op == `DMIU_OP_WSTORE) begin
         wr_mem  = 1'b1;
         wr_addr = {1'b0, lit[6:0] & `DMIU_FILE_MASK}; // [RULE_10]
      end else if (wr && paddr == `DMIU_MEMD_ADDR) begin
         wr_mem = 1'b1;
      end
   end

   always @(posedge mclk) begin
      if (wr_mem) begin
         if (go_ff && op == `DMIU_OP_WSTORE) begin
            mem_ff[wr_addr] <= working_ff; // [RULE_10]
         end else begin
            mem_ff[wr_addr] <= pwdata[7:0];
         end
      end
   end

   // instruction execution, one cycle after the control write
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         working_ff <= 8'h00;
         bank_select_register_ff <= 4'h0;
         program_counter_high_latch_ff <= 7'h00;
         zero_flag_ff <= 1'b0;
         done_ff <= 1'b0;
         pointer_register_ff[0] <= 16'h0000;
         pointer_register_ff[1] <= 16'h0000;
      end else begin
         done_ff <= go_ff;
         if (go_ff) begin
            case (op)
               `DMIU_OP_ILOAD, `DMIU_OP_ILOADK: begin
                  working_ff <= nxt_w; // [RULE_01]
                  zero_flag_ff <= (nxt_w == 8'h00); // [RULE_06]
                  pointer_register_ff[sel] <= nxt_ptr; // [RULE_04]
               end
               `DMIU_OP_BANK: begin
                  bank_select_register_ff <= lit[3:0] & `DMIU_BSR_MASK; // [RULE_07]
               end
               `DMIU_OP_PLATCH: begin
                  program_counter_high_latch_ff <= lit[6:0]; // [RULE_08]
               end
               `DMIU_OP_WLIT: begin
                  working_ff <= lit; // [RULE_09]
               end
               default: begin
                  working_ff <= working_ff;
               end
            endcase
         end else if (wr) begin
            if (paddr == `DMIU_W_ADDR) working_ff <= pwdata[7:0];
            if (paddr == `DMIU_PTR0_ADDR)
               pointer_register_ff[0] <= pwdata[15:0];
            if (paddr == `DMIU_PTR1_ADDR)
               pointer_register_ff[1] <= pwdata[15:0];
         end
      end
   end

   // apb slave: one wait state, writes land at the pready edge
   always @* begin
      nxt_err   = 1'b0;
      nxt_rdata = 32'h00000000;
      case (paddr)
         `DMIU_CTRL_ADDR: nxt_rdata = {31'h0, go_ff};
         `DMIU_INSN_ADDR: nxt_rdata = {16'h0000, insn_ff};
         `DMIU_W_ADDR:    nxt_rdata = {24'h000000, working_ff};
         `DMIU_BSR_ADDR:  nxt_rdata = {28'h0000000, bank_select_register_ff};
         `DMIU_PCH_ADDR:
            nxt_rdata = {25'h0, program_counter_high_latch_ff};
         `DMIU_PTR0_ADDR: nxt_rdata = {16'h0000, pointer_register_ff[0]};
         `DMIU_PTR1_ADDR: nxt_rdata = {16'h0000, pointer_register_ff[1]};
         `DMIU_STAT_ADDR: nxt_rdata = {30'h0, go_ff, zero_flag_ff};
         `DMIU_MEMA_ADDR: nxt_rdata = {24'h000000, mem_addr_ff};
         `DMIU_MEMD_ADDR: nxt_rdata = {24'h000000, mem_ff[mem_addr_ff]};
         default:         nxt_err   = 1'b1;
      endcase
   end

   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         insn_ff <= 16'h0000;
         go_ff   <= 1'b0;
         mem_addr_ff <= 8'h00;
      end else begin
         pready  <= acc;
         pslverr <= acc & nxt_err;
         prdata  <= (acc & ~pwrite) ? nxt_rdata : 32'h00000000;
         go_ff   <= wr && paddr == `DMIU_CTRL_ADDR && pwdata[0];
         if (wr && paddr == `DMIU_INSN_ADDR) insn_ff <= pwdata[15:0];
         if (wr && paddr == `DMIU_MEMA_ADDR) mem_addr_ff <= pwdata[7:0];
      end
   end

endmodule // dmiu_core
`default_nettype wire

// ### testbench/dmiu_chk.sv
// assertion checker for the data move unit ports
`timescale 1ns/1ps
`default_nettype none
module dmiu_chk (
   input wire logic        mclk,
   input wire logic        rstn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [31:0] prdata,
   input wire logic [7:0]  working_ff,
   input wire logic [3:0]  bank_select_register_ff,
   input wire logic [6:0]  program_counter_high_latch_ff,
   input wire logic        zero_flag_ff,
   input wire logic        done_ff
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   AST_ONE_WAIT:
      assert property (psel && $rose(penable) |=> pready) else $error("late");
   AST_READY_PULSE:
      assert property (pready |=> !pready) else $error("long ready");
   AST_ERR_WITH_READY:
      assert property (pslverr |-> pready) else $error("stray error");
   AST_RDATA_IDLE:
      assert property (!pready |-> prdata == 32'h0) else $error("rdata");
   AST_DONE_PULSE:
      assert property (done_ff |=> !done_ff) else $error("long done");
   AST_Z_FOLLOWS_W:
      assert property ($changed(zero_flag_ff) |-> zero_flag_ff ==
         (working_ff == 8'h00) ##[0:1] done_ff) else $error("zero flag");
   AST_BANK_NO_FLAG:
      assert property ($changed(bank_select_register_ff) |->
         $stable(zero_flag_ff) ##[0:1] done_ff) else $error("bank");
   AST_PCH_NO_FLAG:
      assert property ($changed(program_counter_high_latch_ff) |->
         $stable(zero_flag_ff) ##[0:1] done_ff) else $error("latch");
   cover property (done_ff);
   cover property (pslverr);
   cover property ($rose(zero_flag_ff));
endmodule // dmiu_chk
bind dmiu_core dmiu_chk i_dmiu_chk (.*);
`default_nettype wire

// ### testbench/dmiu_core_bench.sv
// self-checking bench for the data move unit
`timescale 1ns/1ps
`default_nettype none
`include "dmiu_regs.vh"
module dmiu_core_bench;
   logic        mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, pready, pslverr, zero_flag_ff, done_ff, err, z;
   logic [11:0] paddr = 12'h000, pa;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [7:0]  working_ff, lit, mem [256];
   logic [3:0]  bank_select_register_ff;
   logic [6:0]  program_counter_high_latch_ff;
   logic [15:0] ptr, ea, np;
   logic [5:0]  o;
   int          fail_count = 0, n_compared = 0, k;
   always #25 mclk = ~mclk;
   dmiu_core i_dmiu_core (.*);
   // entered just after a rising edge; always leaves one idle cycle
   task automatic ap(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic chk(input string s, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s exp %h got %h", s, e, g);
      end
   endtask
   // go is a one-cycle strobe; execute and done both land inside the control write, the three edges only add margin
   task automatic ex(input logic [31:0] i);
      ap(1'b1, `DMIU_INSN_ADDR, i);
      ap(1'b1, `DMIU_CTRL_ADDR, 32'h1);
      repeat (3) @(posedge mclk);
   endtask
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #2ms;
      fail_count++;
      final_report;
   end
   initial begin
      k = $urandom(86511);
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      chk("reset", 32'h0, {working_ff, zero_flag_ff, done_ff});
      // every fifth byte zero so the flag is seen both ways
      for (k = 0; k < 256; k++) begin
         mem[k] = (k % 5 == 0) ? 8'h00 : 8'($urandom);
         ap(1'b1, `DMIU_MEMA_ADDR, 32'(k));
         ap(1'b1, `DMIU_MEMD_ADDR, {24'h0, mem[k]});
      end
      // first sixteen sit on the wrap corners 0000 and FFFF
      for (k = 0; k < 48; k++) begin
         ptr = (k < 16) ? {16{k[3]}} : 16'($urandom);
         pa = k[2] ? `DMIU_PTR1_ADDR : `DMIU_PTR0_ADDR;
         ap(1'b1, pa, {16'h0, ptr});
         if (k < 32) begin
            ex({18'h0, k[1:0], k[2], `DMIU_OP_ILOAD, 8'h00});
            np = k[0] ? ptr - 16'h1 : ptr + 16'h1;
            ea = k[1] ? ptr : np;
         end else begin
            o = (k == 32) ? 6'h20 : (k == 33) ? 6'h1F : 6'($urandom);
            ex({18'h0, 2'h0, k[2], `DMIU_OP_ILOADK, 2'h0, o});
            np = ptr;
            ea = ptr + {{10{o[5]}}, o};
         end
         chk("w", {24'h0, mem[ea[7:0]]}, {24'h0, working_ff});
         chk("z", {31'h0, mem[ea[7:0]] == 8'h00}, {31'h0, zero_flag_ff});
         ap(1'b0, pa, 32'h0);
         chk("ptr", {16'h0, np}, rd);
      end
      $display("indirect load test done");
      for (k = 0; k < 20; k++) begin
         lit = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
         z = zero_flag_ff;
         ex({21'h0, `DMIU_OP_BANK, 4'h0, lit[3:0]});
         chk("bank", {28'h0, lit[3:0]}, {28'h0, bank_select_register_ff});
         ex({21'h0, `DMIU_OP_PLATCH, 1'b0, lit[6:0]});
         chk("pch", {25'h0, lit[6:0]}, {25'h0, program_counter_high_latch_ff});
         ex({21'h0, `DMIU_OP_WLIT, lit});
         chk("wlit", {24'h0, lit}, {24'h0, working_ff});
         ex({21'h0, `DMIU_OP_WSTORE, 1'b0, lit[6:0]});
         ap(1'b1, `DMIU_MEMA_ADDR, {25'h0, lit[6:0]});
         ap(1'b0, `DMIU_MEMD_ADDR, 32'h0);
         chk("store", {24'h0, lit}, rd);
         chk("flag", {31'h0, z}, {31'h0, zero_flag_ff});
      end
      $display("literal and store test done");
      ap(1'b0, 12'hFFC, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      chk("bad rd", 32'h0, rd);
      $display("unmapped access test done");
      final_report;
   end
endmodule // dmiu_core_bench
`default_nettype wire
